// >>> common/dpa_pkg.sv
// Shared constants and helpers for the dual port parallel io adapter
package dpa_pkg;

  // ==========================================================
  // Widths and register selects
  localparam int        PORT_WIDTH   = 8;
  localparam logic [1:0] SEL_PORT_A  = 2'h0;
  localparam logic [1:0] SEL_CTRL_A  = 2'h1;
  localparam logic [1:0] SEL_PORT_B  = 2'h2;
  localparam logic [1:0] SEL_CTRL_B  = 2'h3;

  // ==========================================================
  // Control register field positions
  localparam int CTRL_EN_FIRST    = 0;
  localparam int CTRL_POL_FIRST   = 1;
  localparam int CTRL_ACCESS      = 2;
  localparam int CTRL_EN_SECOND   = 3;
  localparam int CTRL_POL_SECOND  = 4;
  localparam int CTRL_MODE_SECOND = 5;
  localparam int CTRL_FLAG_SECOND = 6;
  localparam int CTRL_FLAG_FIRST  = 7;
  localparam int CTRL_WR_BITS     = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [7:0] RESET_PORT = 8'h00;
  localparam logic [7:0] RESET_DIR  = 8'h00;

  // ==========================================================
  // Processor bus sync vector bit positions
  localparam int BUS_PHI2   = 15;
  localparam int BUS_RW     = 14;
  localparam int BUS_CS0    = 13;
  localparam int BUS_CS1    = 12;
  localparam int BUS_CS2_N  = 11;
  localparam int BUS_SEL_HI = 10;
  localparam int BUS_SEL_LO = 9;
  localparam int BUS_INIT_N = 8;
  localparam int BUS_WIDTH  = 16;

  // Bus cycle states, Gray from idle to commit; the return to idle flips both bits
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h0,
    BUS_STROBE = 2'h1,
    BUS_COMMIT = 2'h3
  } dpa_bus_state_type;

  // Active edge between two samples
  function automatic logic dpa_edge_hit(input logic prev, input logic cur,
                                        input logic rising);
    dpa_edge_hit = rising ? (cur & ~prev) : (prev & ~cur);
  endfunction

endpackage

// >>> common/dpa_side_if.sv
// Carrier between the bus front end and one side's control logic
`timescale 1ns/1ns
interface dpa_side_if;
  import dpa_pkg::*;
  logic       clear;     // Init clear
  logic       ctrl_wr;   // Control write pulse
  logic [7:0] wr_data;   // Control write data
  logic       flag_clr;  // Data read clears flags
  logic       first_in;  // Synced first control input
  logic       second_in; // Synced second control input
  logic [7:0] control;   // Control register view
  logic       irq;       // Request active, high true

  modport front (output clear, ctrl_wr, wr_data, flag_clr, first_in,
                 second_in, input control, irq);
  modport side  (input clear, ctrl_wr, wr_data, flag_clr, first_in,
                 second_in, output control, irq);
endinterface

// >>> design/dpa_side_ctrl.sv
// Control register, edge flags and request logic of one side
`timescale 1ns/1ns
module dpa_side_ctrl
  import dpa_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  reset,
  // Front end link
  dpa_side_if.side   link
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [5:0] ctrl;
    logic [1:0] flags;  // [1] first, [0] second
    logic       prev_first;
    logic       prev_second;
    logic       primed;
  } dpa_side_state_type;

  dpa_side_state_type state;
  dpa_side_state_type next_state;

  logic hit_first;
  logic hit_second;

  // Edge compare against prior sample
  always_comb
  begin
    hit_first  = state.primed & dpa_edge_hit(state.prev_first, link.first_in,
                   state.ctrl[CTRL_POL_FIRST]);
    hit_second = state.primed & ~state.ctrl[CTRL_MODE_SECOND]
               & dpa_edge_hit(state.prev_second, link.second_in,
                   state.ctrl[CTRL_POL_SECOND]);
  end

  // Next state
  always_comb
  begin
    next_state             = state;
    next_state.prev_first  = link.first_in;
    next_state.prev_second = link.second_in;
    next_state.primed      = 1'b1;
    if (link.ctrl_wr)
      next_state.ctrl = link.wr_data[CTRL_WR_BITS-1:0];
    // Clear first, then a coincident edge wins
    if (link.flag_clr)
      next_state.flags = 2'b00;
    if (hit_first)
      next_state.flags[1] = 1'b1;
    if (hit_second)
      next_state.flags[0] = 1'b1;
    if (link.clear)
    begin
      next_state      = '0;
      next_state.ctrl = RESET_CTRL[CTRL_WR_BITS-1:0];
    end
  end

  // Register
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= '0;
    else
      state <= next_state;
  end

  // Outputs to the front end
  assign link.control = {state.flags, state.ctrl};
  assign link.irq = (state.flags[1] & state.ctrl[CTRL_EN_FIRST])
                  | (state.flags[0] & state.ctrl[CTRL_EN_SECOND]);

endmodule // dpa_side_ctrl

// >>> design/dpa_top.sv
// Dual port parallel io adapter: bus front end and both ports
`timescale 1ns/1ns
module dpa_top
  import dpa_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Processor bus
  input  wire logic                  phi2,
  input  wire logic                  rw,
  input  wire logic                  select_high_first,
  input  wire logic                  select_high_second,
  input  wire logic                  select_low_n,
  input  wire logic                  sel_hi,
  input  wire logic                  sel_lo,
  input  wire logic                  init_n,
  input  wire logic [7:0]            data_in,
  output logic      [7:0]            data_out,
  output logic                       data_oe,
  // Port A pins and control inputs
  input  wire logic [PORT_WIDTH-1:0] port_a_pins_in,
  output logic      [PORT_WIDTH-1:0] port_a_pins_out,
  output logic      [PORT_WIDTH-1:0] port_a_pins_oe,
  input  wire logic                  a_edge_in_first,
  input  wire logic                  a_edge_in_second,
  // Port B pins and control inputs
  input  wire logic [PORT_WIDTH-1:0] port_b_pins_in,
  output logic      [PORT_WIDTH-1:0] port_b_pins_out,
  output logic      [PORT_WIDTH-1:0] port_b_pins_oe,
  input  wire logic                  b_edge_in_first,
  input  wire logic                  b_edge_in_second,
  // Open-drain interrupt requests
  input  wire logic                  a_int_request_n_in,
  output logic                       a_int_request_n_out,
  output logic                       a_int_request_n_oe,
  input  wire logic                  b_int_request_n_in,
  output logic                       b_int_request_n_out,
  output logic                       b_int_request_n_oe
);

  // ==========================================================
  // State of the front end
  typedef struct packed {
    // Two-stage synchronisers
    logic [BUS_WIDTH-1:0]  bus_meta;
    logic [BUS_WIDTH-1:0]  bus_sync;
    logic [PORT_WIDTH-1:0] pa_meta;
    logic [PORT_WIDTH-1:0] pa_sync;
    logic [PORT_WIDTH-1:0] pb_meta;
    logic [PORT_WIDTH-1:0] pb_sync;
    logic [3:0]            edge_meta;
    logic [3:0]            edge_sync;
    // Bus cycle tracking
    logic                  phi2_prev;
    dpa_bus_state_type     bus_state;
    logic                  lat_sel;
    logic                  lat_rw;
    logic [1:0]            lat_rs;
    logic [7:0]            lat_data;
    // Port registers
    logic [PORT_WIDTH-1:0] port_a_data;
    logic [PORT_WIDTH-1:0] port_a_direction;
    logic [PORT_WIDTH-1:0] port_b_data;
    logic [PORT_WIDTH-1:0] port_b_direction;
    // Pulses toward the side logic
    logic [1:0]            side_wr;   // [1] A, [0] B
    logic [1:0]            side_clr;  // [1] A, [0] B
    logic [7:0]            side_data;
    // Registered outputs
    logic [7:0]            data_out;
    logic                  data_oe;
    logic                  irq_a;
    logic                  irq_b;
  } dpa_top_state_type;

  dpa_top_state_type state;
  dpa_top_state_type next_state;

  // Links to the two side controllers
  dpa_side_if side_a_link ();
  dpa_side_if side_b_link ();

  // ==========================================================
  // Helpers

  // Chip is addressed by all three selects
  function automatic logic chip_hit(input logic [BUS_WIDTH-1:0] v);
    chip_hit = v[BUS_CS0] & v[BUS_CS1] & ~v[BUS_CS2_N];
  endfunction

  // Register select pair from a sync vector
  function automatic logic [1:0] reg_sel(input logic [BUS_WIDTH-1:0] v);
    reg_sel = {v[BUS_SEL_HI], v[BUS_SEL_LO]};
  endfunction

  // Port B read: stored bit on outputs, pin on inputs
  function automatic logic [PORT_WIDTH-1:0] mix_port(
    input logic [PORT_WIDTH-1:0] stored,
    input logic [PORT_WIDTH-1:0] pins,
    input logic [PORT_WIDTH-1:0] dir);
    mix_port = (stored & dir) | (pins & ~dir);
  endfunction

  // ==========================================================
  // Decoded bus view
  logic                 phi2_now;
  logic                 init_now;
  logic                 phi2_rise;
  logic                 phi2_fall;
  logic                 live_sel;
  logic [1:0]           live_rs;
  logic                 access_a;
  logic                 access_b;
  logic [7:0]           read_value;

  always_comb
  begin
    phi2_now  = state.bus_sync[BUS_PHI2];
    init_now  = state.bus_sync[BUS_INIT_N];
    phi2_rise = phi2_now & ~state.phi2_prev;
    phi2_fall = ~phi2_now & state.phi2_prev;
    live_sel  = chip_hit(state.bus_sync);
    live_rs   = reg_sel(state.bus_sync);
    access_a  = side_a_link.control[CTRL_ACCESS];
    access_b  = side_b_link.control[CTRL_ACCESS];
  end

  // Read data multiplexer
  always_comb
  begin
    case (live_rs)
      SEL_PORT_A:
        if (access_a)
          read_value = state.pa_sync;
        else
          read_value = state.port_a_direction;
      SEL_CTRL_A:
        read_value = side_a_link.control;
      SEL_PORT_B:
        if (access_b)
          read_value = mix_port(state.port_b_data, state.pb_sync,
                                state.port_b_direction);
        else
          read_value = state.port_b_direction;
      default:
        read_value = side_b_link.control;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_state = state;

    // Synchroniser chains for the bus, port pin and edge inputs
    next_state.bus_meta  = {phi2, rw, select_high_first, select_high_second,
                            select_low_n, sel_hi, sel_lo, init_n, data_in};
    next_state.bus_sync  = state.bus_meta;
    next_state.pa_meta   = port_a_pins_in;
    next_state.pa_sync   = state.pa_meta;
    next_state.pb_meta   = port_b_pins_in;
    next_state.pb_sync   = state.pb_meta;
    next_state.edge_meta = {a_edge_in_first, a_edge_in_second,
                            b_edge_in_first, b_edge_in_second};
    next_state.edge_sync = state.edge_meta;
    next_state.phi2_prev = phi2_now;

    // Pulses last one cycle
    next_state.side_wr  = 2'b00;
    next_state.side_clr = 2'b00;

    // Bus cycle sequence
    case (state.bus_state)
      BUS_IDLE:
      begin
        next_state.data_oe = 1'b0;
        if (phi2_rise)
          next_state.bus_state = BUS_STROBE;
      end
      BUS_STROBE:
      begin
        if (phi2_now)
        begin
          // Track address and data while phase two is high
          next_state.lat_sel  = live_sel;
          next_state.lat_rw   = state.bus_sync[BUS_RW];
          next_state.lat_rs   = live_rs;
          next_state.lat_data = state.bus_sync[7:0];
          next_state.data_oe  = live_sel & state.bus_sync[BUS_RW];
          next_state.data_out = read_value;
        end
        if (phi2_fall)
        begin
          next_state.data_oe   = 1'b0;
          next_state.bus_state = BUS_COMMIT;
        end
      end
      BUS_COMMIT:
      begin
        next_state.bus_state = BUS_IDLE;
        if (state.lat_sel && state.lat_rw)
        begin
          // Reading a data location clears that side's flags
          if (state.lat_rs == SEL_PORT_A && access_a)
            next_state.side_clr[1] = 1'b1;
          if (state.lat_rs == SEL_PORT_B && access_b)
            next_state.side_clr[0] = 1'b1;
        end
        else if (state.lat_sel)
        begin
          // Write lands after the trailing edge
          next_state.side_data = state.lat_data;
          case (state.lat_rs)
            SEL_PORT_A:
              if (access_a)
                next_state.port_a_data = state.lat_data;
              else
                next_state.port_a_direction = state.lat_data;
            SEL_CTRL_A:
              next_state.side_wr[1] = 1'b1;
            SEL_PORT_B:
              if (access_b)
                next_state.port_b_data = state.lat_data;
              else
                next_state.port_b_direction = state.lat_data;
            default:
              next_state.side_wr[0] = 1'b1;
          endcase
        end
      end
      default:
        next_state.bus_state = BUS_IDLE;
    endcase

    // Interrupt request levels
    next_state.irq_a = side_a_link.irq;
    next_state.irq_b = side_b_link.irq;

    // Init pin clears all registers, keeps synchronisers and the phase two sample phi2_prev
    if (!init_now)
    begin
      next_state.bus_state        = BUS_IDLE;
      next_state.lat_sel          = 1'b0;
      next_state.lat_rw           = 1'b0;
      next_state.lat_rs           = 2'b00;
      next_state.lat_data         = 8'h00;
      next_state.port_a_data      = RESET_PORT;
      next_state.port_a_direction = RESET_DIR;
      next_state.port_b_data      = RESET_PORT;
      next_state.port_b_direction = RESET_DIR;
      next_state.side_wr          = 2'b00;
      next_state.side_clr         = 2'b00;
      next_state.side_data        = 8'h00;
      next_state.data_out         = 8'h00;
      next_state.data_oe          = 1'b0;
      next_state.irq_a            = 1'b0;
      next_state.irq_b            = 1'b0;
    end
  end

  // ==========================================================
  // Register
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= '0;
    else
      state <= next_state;
  end

  // ==========================================================
  // Side controller hookup
  assign side_a_link.clear     = ~init_now;
  assign side_a_link.ctrl_wr   = state.side_wr[1];
  assign side_a_link.wr_data   = state.side_data;
  assign side_a_link.flag_clr  = state.side_clr[1];
  assign side_a_link.first_in  = state.edge_sync[3];
  assign side_a_link.second_in = state.edge_sync[2];

  assign side_b_link.clear     = ~init_now;
  assign side_b_link.ctrl_wr   = state.side_wr[0];
  assign side_b_link.wr_data   = state.side_data;
  assign side_b_link.flag_clr  = state.side_clr[0];
  assign side_b_link.first_in  = state.edge_sync[1];
  assign side_b_link.second_in = state.edge_sync[0];

  // Side A control and flags
  dpa_side_ctrl side_a_ctrl (
    .clk   (clk),
    .reset (reset),
    .link  (side_a_link.side)
  );

  // Side B control and flags
  dpa_side_ctrl side_b_ctrl (
    .clk   (clk),
    .reset (reset),
    .link  (side_b_link.side)
  );

  // ==========================================================
  // Pin outputs
  assign data_out        = state.data_out;
  assign data_oe         = state.data_oe;
  assign port_a_pins_out = state.port_a_data;
  assign port_a_pins_oe  = state.port_a_direction;
  assign port_b_pins_out = state.port_b_data;
  assign port_b_pins_oe  = state.port_b_direction;

  // Open drain: pull low only while requesting
  assign a_int_request_n_out = 1'b0;
  assign a_int_request_n_oe  = state.irq_a;
  assign b_int_request_n_out = 1'b0;
  assign b_int_request_n_oe  = state.irq_b;

endmodule // dpa_top

// >>> dv/dpa_periph_model.sv
// Peripheral-side model that resolves both port pin buses
`timescale 1ns/1ns
module dpa_periph_model
  import dpa_pkg::*;
(
  // Device side of the pins
  input  wire logic [PORT_WIDTH-1:0] port_a_pins_out,
  input  wire logic [PORT_WIDTH-1:0] port_a_pins_oe,
  input  wire logic [PORT_WIDTH-1:0] port_b_pins_out,
  input  wire logic [PORT_WIDTH-1:0] port_b_pins_oe,
  // Peripheral drivers set by the bench
  input  wire logic [PORT_WIDTH-1:0] ext_a,
  input  wire logic [PORT_WIDTH-1:0] ext_a_en,
  input  wire logic [PORT_WIDTH-1:0] ext_b,
  input  wire logic [PORT_WIDTH-1:0] ext_b_en,
  // Resolved pin levels
  output logic      [PORT_WIDTH-1:0] port_a_pins_in,
  output logic      [PORT_WIDTH-1:0] port_b_pins_in
);
  // Port A has pull-ups, so a low from either party wins
  assign port_a_pins_in = (~port_a_pins_oe | port_a_pins_out)
                        & (~ext_a_en | ext_a);
  // Port B loads override; a floating line reads the inverse of its stored output bit
  assign port_b_pins_in = (ext_b_en & ext_b)
                        | (~ext_b_en & port_b_pins_oe & port_b_pins_out)
                        | (~ext_b_en & ~port_b_pins_oe & ~port_b_pins_out);
endmodule // dpa_periph_model

// >>> dv/dpa_top_asserts.sv
// Port-level assertions for the dual port parallel io adapter
`timescale 1ns/1ns
module dpa_top_asserts
  import dpa_pkg::*;
(
  // Clock, reset and processor bus
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  phi2,
  input wire logic                  rw,
  input wire logic                  select_high_first,
  input wire logic                  select_high_second,
  input wire logic                  select_low_n,
  input wire logic                  init_n,
  input wire logic                  data_oe,
  // Ports, control inputs and requests
  input wire logic [PORT_WIDTH-1:0] port_a_pins_out,
  input wire logic [PORT_WIDTH-1:0] port_a_pins_oe,
  input wire logic [PORT_WIDTH-1:0] port_b_pins_out,
  input wire logic [PORT_WIDTH-1:0] port_b_pins_oe,
  input wire logic                  a_edge_in_first,
  input wire logic                  a_edge_in_second,
  input wire logic                  b_edge_in_first,
  input wire logic                  b_edge_in_second,
  input wire logic                  a_int_request_n_out,
  input wire logic                  a_int_request_n_oe,
  input wire logic                  b_int_request_n_out,
  input wire logic                  b_int_request_n_oe
);
  // ==========================================================
  // Ages since bus and edge activity, saturating at 15
  logic [3:0] rd_age;
  logic [3:0] fall_age;
  logic [3:0] ea_age;
  logic [3:0] eb_age;
  logic [4:0] last;

  function automatic logic [3:0] inc(input logic [3:0] v);
    inc = (v == 4'hf) ? v : v + 4'h1;
  endfunction

  // Track selected reads, strobe ends, init and input changes
  always_ff @(posedge clk)
  begin
    last <= {phi2, a_edge_in_first, a_edge_in_second,
             b_edge_in_first, b_edge_in_second};
    if (reset)
    begin
      rd_age   <= 4'hf;
      fall_age <= 4'hf;
      ea_age   <= 4'hf;
      eb_age   <= 4'hf;
    end
    else
    begin
      rd_age   <= (phi2 & rw & select_high_first & select_high_second
                   & ~select_low_n) ? 4'h0 : inc(rd_age);
      fall_age <= ((last[4] & ~phi2) | ~init_n) ? 4'h0 : inc(fall_age);
      ea_age   <= (last[3:2] != {a_edge_in_first, a_edge_in_second})
                  ? 4'h0 : inc(ea_age);
      eb_age   <= (last[1:0] != {b_edge_in_first, b_edge_in_second})
                  ? 4'h0 : inc(eb_age);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // Properties
  a_req_open_drain: assert property (
    !a_int_request_n_out && !b_int_request_n_out)
    else $error("Request data line not held low");
  a_reset_quiet: assert property (
    $past(reset) |-> !data_oe && port_a_pins_oe == 8'h00
    && port_b_pins_oe == 8'h00 && !a_int_request_n_oe)
    else $error("Outputs active right after reset");
  a_read_drives_bus: assert property (
    $rose(data_oe) |-> rd_age <= 4'h6)
    else $error("Data bus driven without selected read");
  a_bus_release: assert property (
    $fell(phi2) |-> ##[1:6] !data_oe)
    else $error("Data bus held after strobe end");
  a_port_a_commit: assert property (
    ($changed(port_a_pins_out) || $changed(port_a_pins_oe))
    |-> fall_age <= 4'h6)
    else $error("Port A register changed outside commit");
  a_port_b_commit: assert property (
    ($changed(port_b_pins_out) || $changed(port_b_pins_oe))
    |-> fall_age <= 4'h6)
    else $error("Port B register changed outside commit");
  a_req_a_cause: assert property (
    $rose(a_int_request_n_oe) |-> ea_age <= 4'h8 || fall_age <= 4'h8)
    else $error("Request A raised without cause");
  a_req_a_clear: assert property (
    $fell(a_int_request_n_oe) |-> fall_age <= 4'h8)
    else $error("Request A dropped without access");
  a_req_b_cause: assert property (
    $rose(b_int_request_n_oe) |-> eb_age <= 4'h8 || fall_age <= 4'h8)
    else $error("Request B raised without cause");
  a_req_b_clear: assert property (
    $fell(b_int_request_n_oe) |-> fall_age <= 4'h8)
    else $error("Request B dropped without access");

  c_read: cover property ($rose(data_oe));
  c_req_a: cover property ($rose(a_int_request_n_oe));
  c_clr_b: cover property ($fell(b_int_request_n_oe));
endmodule // dpa_top_asserts

bind dpa_top dpa_top_asserts u_dpa_top_asserts (
  .clk(clk), .reset(reset), .phi2(phi2), .rw(rw),
  .select_high_first(select_high_first),
  .select_high_second(select_high_second),
  .select_low_n(select_low_n), .init_n(init_n), .data_oe(data_oe),
  .port_a_pins_out(port_a_pins_out), .port_a_pins_oe(port_a_pins_oe),
  .port_b_pins_out(port_b_pins_out), .port_b_pins_oe(port_b_pins_oe),
  .a_edge_in_first(a_edge_in_first), .a_edge_in_second(a_edge_in_second),
  .b_edge_in_first(b_edge_in_first), .b_edge_in_second(b_edge_in_second),
  .a_int_request_n_out(a_int_request_n_out),
  .a_int_request_n_oe(a_int_request_n_oe),
  .b_int_request_n_out(b_int_request_n_out),
  .b_int_request_n_oe(b_int_request_n_oe));

// >>> dv/tb_top.sv
// Self-checking testbench of the dual port parallel io adapter
`timescale 1ns/1ns
module tb_top
  import dpa_pkg::*;
;
  localparam logic [2:0] CS_ON = 3'h6;
  logic       clk, reset, phi2, rw, sel_hi, sel_lo, init_n, data_oe;
  logic       select_high_first, select_high_second, select_low_n;
  logic [7:0] data_in, data_out, pa_in, pa_out, pa_oe;
  logic [7:0] pb_in, pb_out, pb_oe, ext_a, ext_a_en, ext_b, ext_b_en;
  logic [3:0] edges;
  logic       ia_oe, ib_oe;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cycles = 0;

  // ==========================================================
  // Design and peripheral
  dpa_top u_dpa_top (.clk(clk), .reset(reset), .phi2(phi2), .rw(rw),
    .select_high_first(select_high_first),
    .select_high_second(select_high_second),
    .select_low_n(select_low_n), .sel_hi(sel_hi), .sel_lo(sel_lo),
    .init_n(init_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .port_a_pins_in(pa_in), .port_a_pins_out(pa_out),
    .port_a_pins_oe(pa_oe), .a_edge_in_first(edges[3]),
    .a_edge_in_second(edges[2]), .port_b_pins_in(pb_in),
    .port_b_pins_out(pb_out), .port_b_pins_oe(pb_oe),
    .b_edge_in_first(edges[1]), .b_edge_in_second(edges[0]),
    .a_int_request_n_in(~ia_oe), .a_int_request_n_out(),
    .a_int_request_n_oe(ia_oe), .b_int_request_n_in(~ib_oe),
    .b_int_request_n_out(), .b_int_request_n_oe(ib_oe));
  dpa_periph_model u_dpa_periph_model (.port_a_pins_out(pa_out),
    .port_a_pins_oe(pa_oe), .port_b_pins_out(pb_out),
    .port_b_pins_oe(pb_oe), .ext_a(ext_a), .ext_a_en(ext_a_en),
    .ext_b(ext_b), .ext_b_en(ext_b_en), .port_a_pins_in(pa_in),
    .port_b_pins_in(pb_in));

  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One strobe, held seven cycles, then a long quiet gap
  task automatic bus(input logic r, input logic [1:0] a,
                     input logic [7:0] d, input logic [2:0] cs,
                     output logic [8:0] q);
    @(posedge clk);
    rw <= r;
    {sel_hi, sel_lo} <= a;
    data_in <= d;
    {select_high_first, select_high_second, select_low_n} <= cs;
    phi2 <= 1'b1;
    wait_n(6);
    q = {data_oe, data_out};
    @(posedge clk);
    phi2 <= 1'b0;
    wait_n(8);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [8:0] q;
    bus(1'b0, a, d, CS_ON, q);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    logic [8:0] q;
    bus(1'b1, a, 8'h00, CS_ON, q);
    chk("read data", e, q[7:0]);
    chk("read enable", 8'h01, {7'h0, q[8]});
  endtask
  task automatic setp(input logic [3:0] v);
    @(posedge clk);
    edges <= v;
    wait_n(10);
  endtask
  task automatic req(input logic [1:0] e);
    chk("requests", {6'h0, e}, {6'h0, ib_oe, ia_oe});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_direction();
    wr(2'h0, 8'hf0);
    wr(2'h1, 8'h04);
    wr(2'h0, 8'ha5);
    chk("dir a", 8'hf0, pa_oe);
    chk("out a", 8'ha5, pa_out);
    rd(2'h1, 8'h04);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h3f);
    wr(2'h1, 8'h00);
    rd(2'h0, 8'hf0);
    wr(2'h1, 8'h04);
  endtask
  task automatic t_ports();
    @(posedge clk);
    ext_a_en <= 8'h8f;
    ext_a <= 8'h03;
    rd(2'h0, 8'h23);
    @(posedge clk);
    ext_a_en <= 8'h00;
    rd(2'h0, 8'haf);
    wr(2'h2, 8'h0f);
    wr(2'h3, 8'h04);
    wr(2'h2, 8'h3c);
    chk("dir b", 8'h0f, pb_oe);
    chk("out b", 8'h3c, pb_out);
    @(posedge clk);
    ext_b_en <= 8'hff;
    ext_b <= 8'h90;
    rd(2'h2, 8'h9c);
    wr(2'h3, 8'h00);
    rd(2'h2, 8'h0f);
  endtask
  task automatic t_flags();
    wr(2'h1, 8'h04);
    setp(4'b1000);
    setp(4'b0000);
    req(2'b00);
    rd(2'h1, 8'h84);
    wr(2'h1, 8'h05);
    req(2'b01);
    rd(2'h0, 8'haf);
    req(2'b00);
    rd(2'h1, 8'h05);
    wr(2'h1, 8'h06);
    setp(4'b1000);
    rd(2'h1, 8'h86);
    rd(2'h0, 8'haf);
    setp(4'b0000);
    rd(2'h1, 8'h06);
    wr(2'h1, 8'h1c);
    setp(4'b0100);
    req(2'b01);
    rd(2'h1, 8'h5c);
    rd(2'h0, 8'haf);
    req(2'b00);
    wr(2'h1, 8'h3c);
    setp(4'b0000);
    setp(4'b0100);
    rd(2'h1, 8'h3c);
    wr(2'h3, 8'h1f);
    setp(4'b0110);
    req(2'b10);
    rd(2'h3, 8'h9f);
    setp(4'b0111);
    rd(2'h3, 8'hdf);
    rd(2'h2, 8'h9c);
    req(2'b00);
    rd(2'h3, 8'h1f);
  endtask
  task automatic t_select_init();
    logic [8:0] q;
    logic [2:0] bad [3] = '{3'h2, 3'h4, 3'h7};
    foreach (bad[i])
    begin
      bus(1'b0, 2'h1, 8'hff, bad[i], q);
      bus(1'b1, 2'h1, 8'h00, bad[i], q);
      chk("idle enable", 8'h00, {7'h0, q[8]});
    end
    rd(2'h1, 8'h3c);
    @(posedge clk);
    init_n <= 1'b0;
    wait_n(5);
    @(posedge clk);
    init_n <= 1'b1;
    wait_n(6);
    chk("oe a b", 8'h00, pa_oe | pb_oe);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
  endtask

  // Main sequence
  initial
  begin
    {clk, phi2, sel_hi, sel_lo, select_high_first, select_high_second} = '0;
    {reset, rw, init_n, select_low_n} = '1;
    {data_in, ext_a, ext_a_en, ext_b, ext_b_en, edges} = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wait_n(6);
    for (int i = 0; i < 4; i++)
      rd(2'(i), 8'h00);
    t_direction();
    t_ports();
    t_flags();
    t_select_init();
    summarize();
  end
endmodule // tb_top
